// ---- rtl/bce_exec.sv ----
/*
 * execute logic for branch_on_overflow, branch_on_zero and the two-word call.
 * assumes fetch holds instr_in, prefetch_in and pc_in steady over the
 * instruction cycle, and that stack, counter and flag logic sit outside.
 */
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none

module bce_exec (
    input  wire logic                     sys_clk_in,
    input  wire logic                     resetn_in,
    // apb slave
    input  wire logic [7:0]               paddr_in,
    input  wire logic                     psel_in,
    input  wire logic                     penable_in,
    input  wire logic                     pwrite_in,
    input  wire logic [31:0]              pwdata_in,
    output logic      [31:0]              prdata_out,
    output logic                          pready_out,
    output logic                          pslverr_out,
    // fetch side
    input  wire logic [15:0]              instr_in,
    input  wire logic                     instr_valid_in,
    input  wire logic [15:0]              prefetch_in,
    input  wire logic [bce_pkg::PC_W-1:0] pc_in,
    // core state
    input  wire logic                     ov_flag_in,
    input  wire logic                     zero_flag_in,
    input  wire logic [7:0]               working_in,
    input  wire logic [7:0]               status_in,
    input  wire logic [3:0]               bank_select_reg_in,
    // results
    output logic      [1:0]               q_phase_out,
    output logic                          pc_load_out,
    output logic      [bce_pkg::PC_W-1:0] pc_value_out,
    output logic                          stack_push_out,
    output logic      [bce_pkg::PC_W-1:0] top_of_stack_out,
    output logic                          flush_out,
    output logic                          busy_out,
    output logic      [7:0]               working_shadow_out,
    output logic      [7:0]               status_shadow_out,
    output logic      [3:0]               bank_select_shadow_out
);

    //------------------------------------------------------------
    // decode function
    //------------------------------------------------------------
    // shared by the decoder and the checks below
    function automatic bce_pkg::bce_kind_e kind_of(input logic [15:0] w,
                                                   input logic        ok);
        kind_of = bce_pkg::BCE_NONE;
        if (ok && w[15:8] == bce_pkg::OP_BR_OVF) begin
            kind_of = bce_pkg::BCE_BR_OVF;
        end else if (ok && w[15:8] == bce_pkg::OP_BR_ZERO) begin
            kind_of = bce_pkg::BCE_BR_ZERO;
        end else if (ok && w[15:9] == bce_pkg::OP_CALL) begin
            kind_of = bce_pkg::BCE_CALL;
        end
    endfunction

    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    logic [1:0]               q_reg;
    bce_pkg::bce_state_e      state_reg;
    bce_pkg::bce_state_e      state_next;
    bce_pkg::bce_kind_e       kind_reg;
    logic [7:0]               lit_reg;
    logic [bce_pkg::PC_W-1:0] pc_reg;
    logic                     ov_reg;
    logic                     z_reg;
    logic                     save_reg;
    logic [7:0]               w_reg;
    logic [7:0]               st_reg;
    logic [3:0]               bank_reg;
    logic                     pc_load_reg;
    logic [bce_pkg::PC_W-1:0] pc_val_reg;
    logic                     push_reg;
    logic [bce_pkg::PC_W-1:0] ret_top_reg;
    logic [7:0]               work_sh_reg;
    logic [7:0]               sts_reg;
    logic [3:0]               bank_sh_reg;
    logic                     en_reg;
    logic [31:0]              prdata_reg;

    //------------------------------------------------------------
    // decode and address arithmetic
    //------------------------------------------------------------
    wire                      dec_slot;
    wire bce_pkg::bce_kind_e  dec_kind;
    wire                      is_q1;
    wire                      is_q3;
    wire                      is_q4;
    wire                      taken;
    wire                      redirect;
    wire [bce_pkg::PC_W-1:0]  br_off;
    wire [bce_pkg::PC_W-1:0]  br_tgt;
    wire [bce_pkg::PC_W-1:0]  seq_pc;
    wire [bce_pkg::PC_W-1:0]  call_tgt;
    wire [bce_pkg::PC_W-1:0]  ret_addr;

    assign is_q1    = (q_reg == bce_pkg::Q1);
    assign is_q3    = (q_reg == bce_pkg::Q3);
    assign is_q4    = (q_reg == bce_pkg::Q4);
    // no decode during the flush cycle: that word was prefetched and dies
    assign dec_slot = is_q1 && (state_reg == bce_pkg::BCE_EXEC);
    assign dec_kind = kind_of(instr_in, instr_valid_in && en_reg);    // [RULE1] [RULE2] [RULE6]
    // condition picks its own flag only
    assign taken    = (kind_reg == bce_pkg::BCE_BR_OVF && ov_reg)     // [RULE1]
                   || (kind_reg == bce_pkg::BCE_BR_ZERO && z_reg);    // [RULE2]
    assign redirect = taken || (kind_reg == bce_pkg::BCE_CALL);
    // sign-extended offset already doubled, so word alignment is kept
    assign br_off   = {{12{lit_reg[7]}}, lit_reg, 1'b0};              // [RULE3]
    assign seq_pc   = pc_reg + bce_pkg::PC_STEP_BRANCH;               // [RULE4]
    assign br_tgt   = seq_pc + br_off;                                // [RULE3] [RULE4]
    // high literal is read from the second word in Q4
    assign call_tgt = {prefetch_in[11:0], lit_reg, 1'b0};             // [RULE6] [RULE9]
    assign ret_addr = pc_reg + bce_pkg::PC_STEP_CALL;                 // [RULE7]

    //------------------------------------------------------------
    // phase counter and cycle state
    //------------------------------------------------------------
    // taken branch and call add one no-operation cycle
    assign state_next = (is_q4 && state_reg == bce_pkg::BCE_EXEC && redirect) ? bce_pkg::BCE_NOP  // [RULE5] [RULE10]
                      : is_q4 ? bce_pkg::BCE_EXEC : state_reg;

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            q_reg     <= bce_pkg::Q1;
            state_reg <= bce_pkg::BCE_EXEC;
        end else begin
            q_reg     <= q_reg + 2'h1;                                // [RULE11]
            state_reg <= state_next;
        end
    end

    //------------------------------------------------------------
    // Q1 decode and literal latch
    //------------------------------------------------------------
    // operands are captured once so a fetch change mid-cycle does no harm, except on prefetch_in, which is read in Q4
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            kind_reg <= bce_pkg::BCE_NONE;
            lit_reg  <= 8'h00;
            pc_reg   <= '0;
            ov_reg   <= 1'b0;
            z_reg    <= 1'b0;
            save_reg <= 1'b0;
            w_reg    <= 8'h00;
            st_reg   <= 8'h00;
            bank_reg <= 4'h0;
        end else if (dec_slot) begin
            kind_reg <= dec_kind;                                     // [RULE11]
            lit_reg  <= instr_in[7:0];
            pc_reg   <= pc_in;
            ov_reg   <= ov_flag_in;
            z_reg    <= zero_flag_in;
            save_reg <= instr_in[bce_pkg::SAVE_BIT];                  // [RULE8]
            w_reg    <= working_in;
            st_reg   <= status_in;
            bank_reg <= bank_select_reg_in;
        end else if (is_q4) begin
            kind_reg <= bce_pkg::BCE_NONE;
        end
    end

    //------------------------------------------------------------
    // Q3 push and shadow copy, Q4 counter write
    //------------------------------------------------------------
    // flags are only read here; this block has no path to write them [RULE12]
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            push_reg    <= 1'b0;
            ret_top_reg <= '0;
            pc_load_reg <= 1'b0;
            pc_val_reg  <= '0;
            work_sh_reg <= 8'h00;
            sts_reg     <= 8'h00;
            bank_sh_reg <= 4'h0;
        end else begin
            push_reg    <= is_q3 && kind_reg == bce_pkg::BCE_CALL;     // [RULE7] [RULE11]
            pc_load_reg <= is_q4 && kind_reg != bce_pkg::BCE_NONE;    // [RULE11]
            if (is_q3 && kind_reg == bce_pkg::BCE_CALL) begin
                ret_top_reg <= ret_addr;                              // [RULE7]
            end
            if (is_q3 && kind_reg == bce_pkg::BCE_CALL && save_reg) begin
                work_sh_reg <= w_reg;                                 // [RULE8]
                sts_reg     <= st_reg;
                bank_sh_reg <= bank_reg;
            end
            // only an executed instruction moves the value, so it holds through flush cycles
            if (is_q4 && kind_reg != bce_pkg::BCE_NONE) begin
                pc_val_reg <= (kind_reg == bce_pkg::BCE_CALL) ? call_tgt  // [RULE9]
                            : taken ? br_tgt : seq_pc;                // [RULE4]
            end
        end
    end

    assign q_phase_out            = q_reg;
    assign pc_load_out            = pc_load_reg;
    assign pc_value_out           = pc_val_reg;
    assign stack_push_out         = push_reg;
    assign top_of_stack_out       = ret_top_reg;
    assign flush_out              = (state_reg == bce_pkg::BCE_NOP);  // [RULE5] [RULE10]
    assign busy_out               = flush_out || kind_reg != bce_pkg::BCE_NONE;
    assign working_shadow_out     = work_sh_reg;
    assign status_shadow_out      = sts_reg;
    assign bank_select_shadow_out = bank_sh_reg;

    //------------------------------------------------------------
    // apb slave
    //------------------------------------------------------------
    // read data is loaded in the setup cycle, so no wait state is needed
    wire        hit_ctrl;
    wire        hit_stat;
    wire        hit_pc;
    wire        addr_ok;
    wire [31:0] rd_mux;

    assign hit_ctrl = (paddr_in == bce_pkg::ADDR_CTRL);
    assign hit_stat = (paddr_in == bce_pkg::ADDR_STAT);
    assign hit_pc   = (paddr_in == bce_pkg::ADDR_LAST_PC);
    assign addr_ok  = hit_ctrl || hit_stat || hit_pc;
    assign rd_mux   = hit_ctrl ? {31'h0, en_reg}
                    : hit_stat ? {27'h0, taken, kind_reg, flush_out, busy_out}
                    : hit_pc   ? {11'h0, pc_val_reg} : 32'h0;

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            en_reg     <= bce_pkg::CTRL_EN_RST;
            prdata_reg <= 32'h0;
        end else begin
            if (psel_in && !penable_in) begin
                prdata_reg <= rd_mux;
            end
            if (psel_in && penable_in && pwrite_in && hit_ctrl) begin
                en_reg <= pwdata_in[bce_pkg::CTRL_EN_BIT];
            end
        end
    end

    assign prdata_out  = prdata_reg;
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !addr_ok;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    wire [bce_pkg::PC_W-1:0] exp_br;
    wire [bce_pkg::PC_W-1:0] exp_seq;

    assign exp_br  = pc_in + bce_pkg::PC_STEP_BRANCH + {{12{instr_in[7]}}, instr_in[7:0], 1'b0};
    assign exp_seq = pc_in + bce_pkg::PC_STEP_BRANCH;

    a_bov_taken_target: assert property ( // [RULE1]
        @(posedge sys_clk_in) disable iff (!resetn_in)
        dec_slot && kind_of(instr_in, instr_valid_in && en_reg) == bce_pkg::BCE_BR_OVF && ov_flag_in
        |-> ##4 pc_load_out && pc_value_out == $past(exp_br, 4))
        else $error("overflow branch target wrong");

    a_bz_untaken_seq: assert property ( // [RULE2]
        @(posedge sys_clk_in) disable iff (!resetn_in)
        dec_slot && kind_of(instr_in, instr_valid_in && en_reg) == bce_pkg::BCE_BR_ZERO && !zero_flag_in
        |-> ##4 pc_load_out && pc_value_out == $past(exp_seq, 4) && !flush_out)
        else $error("untaken zero branch wrong");

    a_bz_taken_target: assert property ( // [RULE3]
        @(posedge sys_clk_in) disable iff (!resetn_in)
        dec_slot && kind_of(instr_in, instr_valid_in && en_reg) == bce_pkg::BCE_BR_ZERO && zero_flag_in
        |-> ##4 pc_value_out == $past(exp_br, 4))
        else $error("zero branch target wrong");

    a_taken_flush_len: assert property ( // [RULE5]
        @(posedge sys_clk_in) disable iff (!resetn_in)
        dec_slot && kind_of(instr_in, instr_valid_in && en_reg) == bce_pkg::BCE_BR_OVF && ov_flag_in
        |-> ##4 flush_out[*4] ##1 !flush_out)
        else $error("taken branch flush length wrong");

    a_call_push_ret: assert property ( // [RULE7]
        @(posedge sys_clk_in) disable iff (!resetn_in)
        dec_slot && kind_of(instr_in, instr_valid_in && en_reg) == bce_pkg::BCE_CALL
        |-> ##3 stack_push_out && top_of_stack_out == $past(pc_in, 3) + bce_pkg::PC_STEP_CALL)
        else $error("call return address wrong");

    a_call_shadow_save: assert property ( // [RULE8]
        @(posedge sys_clk_in) disable iff (!resetn_in)
        dec_slot && kind_of(instr_in, instr_valid_in && en_reg) == bce_pkg::BCE_CALL && instr_in[8]
        |-> ##3 working_shadow_out == $past(working_in, 3) && status_shadow_out == $past(status_in, 3)
            && bank_select_shadow_out == $past(bank_select_reg_in, 3))
        else $error("shadow copy missing");

    a_call_pc_target: assert property ( // [RULE9]
        @(posedge sys_clk_in) disable iff (!resetn_in)
        dec_slot && kind_of(instr_in, instr_valid_in && en_reg) == bce_pkg::BCE_CALL
        |-> ##4 pc_load_out && pc_value_out[8:1] == $past(instr_in[7:0], 4)
            && pc_value_out[20:9] == $past(prefetch_in[11:0], 1) && !pc_value_out[0])
        else $error("call target wrong");

    a_call_nop_cycle: assert property ( // [RULE10]
        @(posedge sys_clk_in) disable iff (!resetn_in)
        dec_slot && kind_of(instr_in, instr_valid_in && en_reg) == bce_pkg::BCE_CALL
        |-> ##1 (!pc_load_out)[*3] ##1 (flush_out && !stack_push_out)[*4] ##1 !flush_out)
        else $error("call cycle count wrong");

    a_phase_slots: assert property ( // [RULE11]
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (stack_push_out |-> q_reg == bce_pkg::Q4) and (pc_load_out |-> q_reg == bce_pkg::Q1))
        else $error("action in wrong phase");

endmodule

`default_nettype wire

// ---- rtl/bce_pkg.sv ----
/*
 * constants, enums and register map of the branch/call execute block.
 * assumes a core clock of 125 MHz with four phase cycles per instruction.
 */
`default_nettype none
//------------------------------------------------------------
// Operation
//------------------------------------------------------------
// Operation
// RULE1: opcode E4 plus offset is branch_on_overflow, taken only when overflow is one.
// RULE2: opcode E0 plus offset is branch_on_zero, taken only when zero is one.
// RULE3: taken branch adds twice the signed offset to the incremented counter.
// RULE4: taken target is address plus 2 plus 2n; untaken goes to address plus 2.
// RULE5: branch lasts one cycle untaken, two taken; second cycle flushes prefetch.
// RULE6: call is two words: 1110110s with k7..0, then 1111 with k19..8; the code does not check the 1111 of the second word.
// RULE7: call pushes address plus 4 onto top_of_stack.
// RULE8: save bit one copies working, status, bank select into shadows; zero keeps them.
// RULE9: the 20-bit call target goes into counter bits 20 down to 1.
// RULE10: call takes two cycles, the second a pipeline no-operation.
// RULE11: Q1 decode, Q2 literal, Q3 process or push, Q4 high literal and write; the code latches the literal in Q1.
// RULE12: none of the three instructions changes any status flag.
package bce_pkg;

    localparam int PC_W = 21;

    // phase codes of the instruction cycle
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;
    localparam int CYCLES_PER_INSTR = 4;
    localparam int CLK_PERIOD_NS    = 8;

    // opcode fields of the upper byte
    localparam logic [7:0] OP_BR_OVF    = 8'hE4;
    localparam logic [7:0] OP_BR_ZERO   = 8'hE0;
    localparam logic [6:0] OP_CALL      = 7'h76;
    localparam logic [3:0] OP_CALL_2ND  = 4'hF;
    localparam int         SAVE_BIT     = 8;

    // pc increments
    localparam logic [PC_W-1:0] PC_STEP_BRANCH = 21'h000002;
    localparam logic [PC_W-1:0] PC_STEP_CALL   = 21'h000004;

    // apb map
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STAT    = 8'h04;
    localparam logic [7:0] ADDR_LAST_PC = 8'h08;
    localparam int         CTRL_EN_BIT  = 0;
    localparam logic       CTRL_EN_RST  = 1'b1;

    typedef enum logic [1:0] {
        BCE_NONE,
        BCE_BR_OVF,
        BCE_BR_ZERO,
        BCE_CALL
    } bce_kind_e;

    typedef enum logic {
        BCE_EXEC,
        BCE_NOP
    } bce_state_e;

endpackage

`default_nettype wire

// ---- sim/tb_top.sv ----
/*
 * self-checking bench for the branch/call execute block.
 * assumes apb answers with no wait states and the four phase
 * count starts at the first edge after reset is released.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_top;

//------------------------------------------------------------
// Signals
//------------------------------------------------------------
    logic        sys_clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [31:0] pwdata_in = 32'h00000000;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic [15:0] instr_in = 16'h0000;
    logic        instr_valid_in = 1'b0;
    logic [15:0] prefetch_in = 16'h0000;
    logic [20:0] pc_in = 21'h000000;
    logic        ov_flag_in = 1'b0;
    logic        zero_flag_in = 1'b0;
    logic [7:0]  working_in = 8'h00;
    logic [7:0]  status_in = 8'h00;
    logic [3:0]  bank_select_reg_in = 4'h0;
    logic [1:0]  q_phase_out;
    logic        pc_load_out;
    logic [20:0] pc_value_out;
    logic        stack_push_out;
    logic [20:0] top_of_stack_out;
    logic        flush_out;
    logic        busy_out;
    logic [7:0]  working_shadow_out;
    logic [7:0]  status_shadow_out;
    logic [3:0]  bank_select_shadow_out;
    int          n_errors = 0;
    int          n_tests = 0;
    logic [15:0] lfsr = 16'hEE89;
    logic        en_model = 1'b1;
    logic [19:0] sh_model = 20'h00000;
    logic [20:0] last_pc = 21'h000000;

    bce_exec bce_exec_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .paddr_in(paddr_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .instr_in(instr_in), .instr_valid_in(instr_valid_in), .prefetch_in(prefetch_in), .pc_in(pc_in),
        .ov_flag_in(ov_flag_in), .zero_flag_in(zero_flag_in), .working_in(working_in),
        .status_in(status_in), .bank_select_reg_in(bank_select_reg_in), .q_phase_out(q_phase_out),
        .pc_load_out(pc_load_out), .pc_value_out(pc_value_out), .stack_push_out(stack_push_out),
        .top_of_stack_out(top_of_stack_out), .flush_out(flush_out), .busy_out(busy_out),
        .working_shadow_out(working_shadow_out), .status_shadow_out(status_shadow_out),
        .bank_select_shadow_out(bank_select_shadow_out));

    // 125 MHz core clock
    always #4 sys_clk_in = ~sys_clk_in;

//------------------------------------------------------------
// Helpers
//------------------------------------------------------------
    // fixed-seed shift register keeps every run identical
    function automatic void nxt(output logic [15:0] r);
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        r = lfsr;
    endfunction

    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask

    // 0 none, 1 overflow branch, 2 zero branch, 3 call
    function automatic logic [1:0] kind_of(input logic [15:0] w, input logic v, input logic e);
        if (!(v && e)) return 2'h0;
        if (w[15:8] == 8'hE4) return 2'h1;
        if (w[15:8] == 8'hE0) return 2'h2;
        if (w[15:9] == 7'h76) return 2'h3;
        return 2'h0;
    endfunction

    function automatic logic [20:0] exp_pc(input logic [15:0] w, input logic [15:0] pf,
                                           input logic [20:0] pc, input logic tk, input logic [1:0] k);
        if (k == 2'h3) return {pf[11:0], w[7:0], 1'b0};
        if (tk) return pc + 21'h000002 + {{12{w[7]}}, w[7:0], 1'b0};
        return pc + 21'h000002;
    endfunction

    // one apb transfer; the request is held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        paddr_in <= a;
        pwrite_in <= wr;
        pwdata_in <= wd;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        chk(n < 50, "apb ready never came");
    endtask

//------------------------------------------------------------
// Instruction driver and checks
//------------------------------------------------------------
    // values are read at rising edges, so each check sees the cycle just ended
    task automatic exec_op(input logic [15:0] w, input logic [15:0] pf, input logic [20:0] pc,
                           input logic ov, input logic z, input logic v);
        logic [1:0]  k;
        logic        tk;
        logic [20:0] pe;
        logic [15:0] r;
        k = kind_of(w, v, en_model);
        tk = (k == 2'h3) || (k == 2'h1 && ov) || (k == 2'h2 && z);
        pe = exp_pc(w, pf, pc, tk, k);
        do @(posedge sys_clk_in); while (q_phase_out !== 2'h3);
        nxt(r);
        instr_in <= w;
        instr_valid_in <= v;
        prefetch_in <= pf;
        pc_in <= pc;
        ov_flag_in <= ov;
        zero_flag_in <= z;
        working_in <= r[7:0];
        status_in <= r[15:8];
        bank_select_reg_in <= r[11:8];
        if (k == 2'h3 && w[8]) sh_model = {r[7:0], r[15:8], r[11:8]};
        if (k != 2'h0) last_pc = pe;
        @(posedge sys_clk_in);
        // scramble sampled inputs so late sampling shows up
        nxt(r);
        instr_valid_in <= 1'b0;
        instr_in <= r;
        pc_in <= {r[4:0], r};
        ov_flag_in <= ~ov;
        zero_flag_in <= ~z;
        working_in <= ~r[7:0];
        status_in <= r[7:0];
        bank_select_reg_in <= r[3:0];
        repeat (2) @(posedge sys_clk_in);
        chk(busy_out === (k != 2'h0), "busy level");
        @(posedge sys_clk_in);
        chk(stack_push_out === (k == 2'h3), "push pulse");
        if (k == 2'h3) chk(top_of_stack_out === pc + 21'h000004, "return address");
        chk(pc_load_out === 1'b0, "early counter load");
        // a taken zero branch offered in the flush cycle must be dropped
        if (tk) begin
            instr_in <= {8'hE0, r[7:0]};
            zero_flag_in <= 1'b1;
            instr_valid_in <= 1'b1;
        end
        @(posedge sys_clk_in);
        instr_valid_in <= 1'b0;
        chk(pc_load_out === (k != 2'h0), "counter load");
        if (k != 2'h0) chk(pc_value_out === pe, "new counter");
        chk(flush_out === tk, "flush start");
        chk({working_shadow_out, status_shadow_out, bank_select_shadow_out} === sh_model, "shadows");
        if (tk) begin
            repeat (3) @(posedge sys_clk_in);
            chk(flush_out === 1'b1, "flush length");
            @(posedge sys_clk_in);
            chk(flush_out === 1'b0 && pc_load_out === 1'b0 && pc_value_out === pe, "flush end");
        end
    endtask

    task automatic wrap_up;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

//------------------------------------------------------------
// Main sequence
//------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic        er;
        logic [15:0] r;
        logic [15:0] o;
        logic [15:0] w;
        repeat (16) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        apb(1'b0, 8'h00, 32'h0, rd, er);
        chk(rd === 32'h00000001 && er === 1'b0, "ctrl reset value");
        apb(1'b1, 8'h04, 32'hFFFFFFFF, rd, er);
        apb(1'b0, 8'h04, 32'h0, rd, er);
        chk(rd === 32'h00000000, "status reset or written");
        apb(1'b1, 8'h0C, 32'hFFFFFFFF, rd, er);
        chk(er === 1'b1, "unmapped write");
        apb(1'b0, 8'h0C, 32'h0, rd, er);
        chk(er === 1'b1 && rd === 32'h00000000, "unmapped read");
        // offset limits, flags swapped, invalid word and both call forms
        exec_op(16'hE47F, 16'h0000, 21'h000100, 1'b1, 1'b0, 1'b1);
        exec_op(16'hE480, 16'h0000, 21'h000100, 1'b1, 1'b0, 1'b1);
        exec_op(16'hE405, 16'h0000, 21'h000300, 1'b0, 1'b1, 1'b1);
        exec_op(16'hE0FF, 16'h0000, 21'h1FFFF0, 1'b0, 1'b1, 1'b1);
        exec_op(16'hE010, 16'h0000, 21'h000400, 1'b1, 1'b0, 1'b1);
        exec_op(16'hEDFF, 16'hFFFF, 21'h000200, 1'b0, 1'b0, 1'b1);
        exec_op(16'hEC34, 16'hF012, 21'h000600, 1'b1, 1'b1, 1'b1);
        exec_op(16'hE07F, 16'h0000, 21'h000800, 1'b0, 1'b1, 1'b0);
        for (int i = 0; i < 16; i++) begin
            nxt(r);
            nxt(o);
            case (r[1:0])
                2'h0: w = {8'hE4, o[7:0]};
                2'h1: w = {8'hE0, o[7:0]};
                2'h2: w = {7'h76, o[8:0]};
                default: w = {4'h0, o[11:0]};
            endcase
            exec_op(w, {r[15:12], o[11:0]}, {r[4:0], o[15:1], 1'b0}, r[2], r[3], ~&r[6:4]);
        end
        apb(1'b0, 8'h08, 32'h0, rd, er);
        chk(rd === {11'h000, last_pc}, "last counter read");
        // decode off: a taken branch must leave the counter alone
        apb(1'b1, 8'h00, 32'h0, rd, er);
        en_model = 1'b0;
        exec_op(16'hE001, 16'h0000, 21'h000A00, 1'b0, 1'b1, 1'b1);
        apb(1'b1, 8'h00, 32'h1, rd, er);
        en_model = 1'b1;
        exec_op(16'hE001, 16'h0000, 21'h000A00, 1'b0, 1'b1, 1'b1);
        wrap_up;
    end

    // run needs well under 2000 cycles
    initial begin
        repeat (6000) @(posedge sys_clk_in);
        n_errors++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        wrap_up;
    end

endmodule

`default_nettype wire
